/* rtl/smccr_regs.sv */
// Configuration, shared memory control and command registers of the controller.
`timescale 1ns/1ps
module smccr_regs
    import smccr_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic [4:0]  io_addr,
    input  wire logic        io_wr,
    input  wire logic        io_rd,
    input  wire logic [7:0]  io_wdata,
    input  wire logic        shm_sel,
    input  wire logic        new_page_enable,
    input  wire logic        page_choice,
    input  wire logic        slot_width_pin,
    input  wire logic        tx_done,
    input  wire logic        tx_abort,
    input  wire logic        rdma_done,
    input  wire logic        rbc_reloaded,
    input  wire logic [23:0] mem_addr,
    input  wire logic        mem_req,
    input  wire logic        mem_wide_req,
    output logic [7:0]       io_rdata,
    output logic             irq_output_style,
    output logic             core_clock_source,
    output logic             full_buffer_mode,
    output logic             config_ab_writable,
    output logic             core_reset,
    output logic             run_cmd,
    output logic             halt_cmd,
    output logic             send_packet,
    output logic [1:0]       page_select,
    output logic [2:0]       remote_dma_cmd,
    output logic             tx_start,
    output logic             rdma_start,
    output logic             rdma_abort,
    output logic             rdma_finish_now,
    output logic             rdma_busy,
    output logic             shm_hit,
    output logic             mem_wide_select_n,
    output logic [15:0]      buf_offset,
    output logic [15:0]      buf_addr_mask
);

    logic [7:0]  cmd_reg;
    logic [7:0]  cmd_next;
    logic [3:0]  cfgc_reg;
    logic [3:0]  cfgc_next;
    logic [7:0]  ctl1_reg;
    logic [7:0]  ctl1_next;
    logic [7:0]  ctl2_reg;
    logic [7:0]  ctl2_next;
    logic        slot_reg;
    logic        busy_reg;
    logic        busy_next;
    logic [7:0]  rdata_next;

    logic        wr_cmd;
    logic        rd_cmd;
    logic        cfgc_open;
    logic        wr_cfgc;
    logic        rd_cfgc;
    logic        wr_ctl1;
    logic        wr_ctl2;
    logic        rd_ctl1;
    logic        rd_ctl2;
    logic        rd_slot;
    logic        io_access;

    logic [2:0]  new_rdma;
    logic        rdma_is_abort;
    logic        rdma_is_cmd;
    logic        tx_set;
    logic        tx_clear;
    logic        start_now;
    logic        finish_now;
    logic        abort_now;

    smccr_size_t win_size;
    logic        win_hit;
    logic [15:0] win_offset;
    logic [15:0] win_mask;

    // Register decode; a write takes precedence when both strobes are high.
    // Shared memory registers decode only the low two address bits, so they alias.
    assign io_access = io_wr || io_rd;
    assign wr_cmd    = io_wr && !shm_sel && (io_addr == SMCCR_CMD_OFF);
    assign rd_cmd    = io_rd && !io_wr && !shm_sel && (io_addr == SMCCR_CMD_OFF);
    assign cfgc_open = new_page_enable && page_choice
                       && ((io_addr == SMCCR_CFGC_OFF_A) || (io_addr == SMCCR_CFGC_OFF_B));
    assign wr_cfgc   = io_wr && !shm_sel && cfgc_open;
    assign rd_cfgc   = io_rd && !io_wr && !shm_sel && cfgc_open;
    assign wr_ctl1   = io_wr && shm_sel && (io_addr[1:0] == SMCCR_CTL1_OFF);
    assign wr_ctl2   = io_wr && shm_sel && (io_addr[1:0] == SMCCR_CTL2_OFF);
    assign rd_ctl1   = io_rd && !io_wr && shm_sel && (io_addr[1:0] == SMCCR_CTL1_OFF);
    assign rd_ctl2   = io_rd && !io_wr && shm_sel && (io_addr[1:0] == SMCCR_CTL2_OFF);
    assign rd_slot   = io_rd && !io_wr && shm_sel && (io_addr[1:0] == SMCCR_SLOT_OFF);

    // Remote DMA command decode. Any code with the top bit set aborts.
    assign new_rdma      = io_wdata[SMCCR_CMD_RDMA_LSB +: 3];
    assign rdma_is_abort = wr_cmd && new_rdma[2];
    assign rdma_is_cmd   = wr_cmd && !new_rdma[2] && (new_rdma != SMCCR_RDMA_NONE);
    // Without a fresh byte count the channel has nothing to move, so it ends at once.
    assign finish_now    = rdma_is_cmd && !rbc_reloaded;
    assign start_now     = rdma_is_cmd && rbc_reloaded;
    assign abort_now     = rdma_is_abort;

    // Transmit request: only a written one starts; a zero never cancels.
    assign tx_set   = wr_cmd && io_wdata[SMCCR_CMD_SEND_BIT] && !cmd_reg[SMCCR_CMD_SEND_BIT];
    assign tx_clear = tx_done || tx_abort;

    always_comb begin
        cmd_next = cmd_reg;
        if (wr_cmd) begin
            cmd_next[SMCCR_CMD_PAGE_LSB +: 2]  = io_wdata[SMCCR_CMD_PAGE_LSB +: 2];
            cmd_next[SMCCR_CMD_RDMA_LSB +: 3]  = new_rdma;
            cmd_next[SMCCR_CMD_HALT_BIT]       = io_wdata[SMCCR_CMD_HALT_BIT];
            cmd_next[SMCCR_CMD_RUN_BIT]        = io_wdata[SMCCR_CMD_RUN_BIT];
        end
        // A written one only counts while no send is active, so a completion in the same cycle as it still clears an active send.
        if (tx_set) begin
            cmd_next[SMCCR_CMD_SEND_BIT] = 1'b1;
        end else if (tx_clear) begin
            cmd_next[SMCCR_CMD_SEND_BIT] = 1'b0;
        end
        // A written zero lands in neither branch, so an active send stays set.
    end

    // A start beats a completion in one cycle so that a fresh request is never lost.
    always_comb begin
        busy_next = busy_reg;
        if (start_now) begin
            busy_next = 1'b1;
        end else if (abort_now || finish_now || rdma_done) begin
            busy_next = 1'b0;
        end
    end

    // Only the upper nibble is stored; the boot memory field below it reads as zero.
    always_comb begin
        cfgc_next = cfgc_reg;
        if (wr_cfgc) begin
            cfgc_next = io_wdata[7:4];
        end
    end

    always_comb begin
        ctl1_next = ctl1_reg;
        if (wr_ctl1) begin
            ctl1_next = io_wdata;
        end
    end

    always_comb begin
        ctl2_next = ctl2_reg;
        if (wr_ctl2) begin
            ctl2_next = {io_wdata[7:6], 1'b0, io_wdata[4:0]};
        end
    end

    // Read mux; unmapped or closed offsets read as zero.
    always_comb begin
        rdata_next = 8'h00;
        if (rd_cmd) begin
            rdata_next = cmd_reg;
        end else if (rd_cfgc) begin
            rdata_next = {cfgc_reg, 4'h0};
        end else if (rd_ctl1) begin
            rdata_next = ctl1_reg;
        end else if (rd_ctl2) begin
            rdata_next = ctl2_reg;
        end else if (rd_slot) begin
            rdata_next = {7'h00, slot_reg};
        end
    end

    smccr_mem_decode u_decode (
        .mem_enable  (ctl1_reg[SMCCR_CTL1_EN_BIT]),
        .full_mode   (cfgc_reg[SMCCR_CFGC_FULL_BIT - 4]),
        .word_width  (ctl2_reg[SMCCR_CTL2_WORD_BIT]),
        .wide_enable (ctl2_reg[SMCCR_CTL2_WIDE_BIT]),
        .base_addr   ({ctl2_reg[4:0], ctl1_reg[5:0]}),
        .host_addr   (mem_addr),
        .win_size    (win_size),
        .hit         (win_hit),
        .offset      (win_offset),
        .mask        (win_mask)
    );

    always_ff @(posedge clk) begin
        if (!resetn) begin
            cmd_reg  <= SMCCR_CMD_RESET;
            cfgc_reg <= SMCCR_CFGC_RESET;
            ctl1_reg <= SMCCR_CTL1_RESET;
            ctl2_reg <= SMCCR_CTL2_RESET;
            busy_reg <= 1'b0;
            slot_reg <= 1'b0;
            io_rdata <= 8'h00;
        end else begin
            cmd_reg  <= cmd_next;
            cfgc_reg <= cfgc_next;
            ctl1_reg <= ctl1_next;
            ctl2_reg <= ctl2_next;
            busy_reg <= busy_next;
            slot_reg <= slot_width_pin;
            // Read data holds between accesses, so a slow host can still collect it.
            if (io_access) begin
                io_rdata <= rdata_next;
            end
        end
    end

    // Mode outputs follow their register bits one cycle after the write.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            irq_output_style   <= 1'b0;
            core_clock_source  <= 1'b0;
            full_buffer_mode   <= 1'b0;
            // The lock bit powers up clear, so registers A and B start writable.
            config_ab_writable <= 1'b1;
            core_reset         <= 1'b0;
            run_cmd            <= 1'b0;
            // The halt bit powers up set, so the core stays offline until it is run.
            halt_cmd           <= 1'b1;
            send_packet        <= 1'b0;
            page_select        <= 2'h0;
            remote_dma_cmd     <= 3'h0;
            rdma_busy          <= 1'b0;
        end else begin
            irq_output_style   <= cfgc_next[SMCCR_CFGC_IRQ_BIT - 4];
            // The core clock mux itself lives beside the clock tree, not here.
            core_clock_source  <= cfgc_next[SMCCR_CFGC_CLK_BIT - 4];
            full_buffer_mode   <= cfgc_next[SMCCR_CFGC_FULL_BIT - 4];
            config_ab_writable <= !cfgc_next[SMCCR_CFGC_LOCK_BIT - 4];
            core_reset         <= ctl1_next[SMCCR_CTL1_RST_BIT];
            run_cmd            <= cmd_next[SMCCR_CMD_RUN_BIT];
            halt_cmd           <= cmd_next[SMCCR_CMD_HALT_BIT];
            send_packet        <= cmd_next[SMCCR_CMD_SEND_BIT];
            page_select        <= cmd_next[SMCCR_CMD_PAGE_LSB +: 2];
            remote_dma_cmd     <= cmd_next[SMCCR_CMD_RDMA_LSB +: 3];
            rdma_busy          <= busy_next;
        end
    end

    // Command pulses, one cycle each, in the cycle after the write.
    // Registering them costs a cycle but keeps them free of decode glitches.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            tx_start        <= 1'b0;
            rdma_start      <= 1'b0;
            rdma_abort      <= 1'b0;
            rdma_finish_now <= 1'b0;
        end else begin
            tx_start        <= tx_set;
            rdma_start      <= start_now;
            rdma_abort      <= abort_now;
            rdma_finish_now <= finish_now;
        end
    end

    // Host memory side, registered one cycle behind the address.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            shm_hit           <= 1'b0;
            mem_wide_select_n <= 1'b1;
            buf_offset        <= 16'h0000;
            buf_addr_mask     <= 16'h1fff;
        end else begin
            shm_hit           <= mem_req && win_hit;
            // Wide select only asserts for a hit while 16-bit access is enabled.
            mem_wide_select_n <= !(mem_req && win_hit && mem_wide_req
                                   && ctl2_reg[SMCCR_CTL2_WIDE_BIT]);
            // Mask and offset follow the stored window a cycle late, two cycles after a size write.
            buf_offset        <= win_offset;
            buf_addr_mask     <= win_mask;
        end
    end

endmodule

/* rtl/smccr_pkg.sv */
// Offsets, field positions, reset values and size codes for the shared memory control block.
package smccr_pkg;

    // Register port offsets.
    localparam logic [4:0] SMCCR_CMD_OFF    = 5'h00;
    localparam logic [4:0] SMCCR_CFGC_OFF_A = 5'h0c;
    localparam logic [4:0] SMCCR_CFGC_OFF_B = 5'h1c;
    localparam logic [1:0] SMCCR_CTL1_OFF   = 2'h0;
    localparam logic [1:0] SMCCR_SLOT_OFF   = 2'h1;
    localparam logic [1:0] SMCCR_CTL2_OFF   = 2'h2;

    // Command register fields.
    localparam int SMCCR_CMD_HALT_BIT = 0;
    localparam int SMCCR_CMD_RUN_BIT  = 1;
    localparam int SMCCR_CMD_SEND_BIT = 2;
    localparam int SMCCR_CMD_RDMA_LSB = 3;
    localparam int SMCCR_CMD_PAGE_LSB = 6;

    // Configuration register C fields.
    localparam int SMCCR_CFGC_FULL_BIT  = 4;
    localparam int SMCCR_CFGC_IRQ_BIT   = 5;
    localparam int SMCCR_CFGC_CLK_BIT   = 6;
    localparam int SMCCR_CFGC_LOCK_BIT  = 7;

    // Shared memory control register fields.
    localparam int SMCCR_SLOT_BIT      = 0;
    localparam int SMCCR_CTL1_EN_BIT   = 6;
    localparam int SMCCR_CTL1_RST_BIT  = 7;
    localparam int SMCCR_CTL2_WORD_BIT = 6;
    localparam int SMCCR_CTL2_WIDE_BIT = 7;

    // Values after reset.
    localparam logic [7:0] SMCCR_CMD_RESET  = 8'h01;
    localparam logic [3:0] SMCCR_CFGC_RESET = 4'h0;
    localparam logic [7:0] SMCCR_CTL1_RESET = 8'h00;
    localparam logic [7:0] SMCCR_CTL2_RESET = 8'h00;

    // Remote DMA command codes.
    localparam logic [2:0] SMCCR_RDMA_NONE = 3'h0;

    // Buffer window sizes in kbytes.
    localparam int SMCCR_WIN_8K  = 8;
    localparam int SMCCR_WIN_16K = 16;
    localparam int SMCCR_WIN_32K = 32;
    localparam int SMCCR_WIN_64K = 64;

    typedef enum logic [1:0] {
        SMCCR_SIZE_8K,
        SMCCR_SIZE_16K,
        SMCCR_SIZE_32K,
        SMCCR_SIZE_64K
    } smccr_size_t;

    // Byte mask of the buffer offset for a window size.
    function automatic logic [15:0] smccr_offset_mask(input smccr_size_t s);
        logic [15:0] m;
        m = 16'h1fff;
        case (s)
            SMCCR_SIZE_16K: m = 16'h3fff;
            SMCCR_SIZE_32K: m = 16'h7fff;
            SMCCR_SIZE_64K: m = 16'hffff;
            default:        m = 16'h1fff;
        endcase
        return m;
    endfunction

endpackage

/* rtl/smccr_mem_decode.sv */
// Shared memory window decoder: window size, base compare and buffer offset.
`timescale 1ns/1ps
module smccr_mem_decode
    import smccr_pkg::*;
(
    input  wire logic        mem_enable,
    input  wire logic        full_mode,
    input  wire logic        word_width,
    input  wire logic        wide_enable,
    input  wire logic [10:0] base_addr,
    input  wire logic [23:0] host_addr,
    output smccr_size_t      win_size,
    output logic             hit,
    output logic [15:0]      offset,
    output logic [15:0]      mask
);

    logic [10:0] cmp_mask;
    logic [10:0] diff;

    // Compatible mode never opens more than 16 kbytes; word width doubles byte width, except in full mode with 16-bit access off.
    always_comb begin
        if (!full_mode) begin
            win_size = word_width ? SMCCR_SIZE_16K : SMCCR_SIZE_8K;
        end else if (word_width && wide_enable) begin
            win_size = SMCCR_SIZE_64K;
        end else begin
            win_size = SMCCR_SIZE_32K;
        end
    end

    assign mask     = smccr_offset_mask(win_size);
    assign cmp_mask = {8'hff, ~mask[15:13]};
    assign diff     = (host_addr[23:13] ^ base_addr) & cmp_mask;
    // Base bits that fall inside a larger window are ignored, so the window stays aligned.
    assign hit      = mem_enable && (diff == 11'h000);
    assign offset   = host_addr[15:0] & mask;

endmodule

/* bench/smccr_regs_checker.sv */
// Port-level assertions for the shared memory control and command registers.
`timescale 1ns/1ps
module smccr_regs_checker (
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic [4:0]  io_addr,
    input wire logic        io_wr,
    input wire logic        io_rd,
    input wire logic [7:0]  io_wdata,
    input wire logic        shm_sel,
    input wire logic        new_page_enable,
    input wire logic        page_choice,
    input wire logic        slot_width_pin,
    input wire logic        tx_done,
    input wire logic        tx_abort,
    input wire logic        rbc_reloaded,
    input wire logic        mem_req,
    input wire logic        mem_wide_req,
    input wire logic [7:0]  io_rdata,
    input wire logic        irq_output_style,
    input wire logic        core_clock_source,
    input wire logic        full_buffer_mode,
    input wire logic        config_ab_writable,
    input wire logic        core_reset,
    input wire logic        send_packet,
    input wire logic        tx_start,
    input wire logic        rdma_abort,
    input wire logic        rdma_finish_now,
    input wire logic        rdma_busy,
    input wire logic        shm_hit,
    input wire logic        mem_wide_select_n
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    wire cmd_wr = io_wr && !shm_sel && io_addr == 5'h00;
    wire cfg_wr = io_wr && !shm_sel && (io_addr == 5'h0c || io_addr == 5'h1c);
    wire shm_rd = io_rd && !io_wr && shm_sel;

    AST_CORE_RESET: assert property (io_wr && shm_sel && io_addr[1:0] == 2'h0
        |=> core_reset == $past(io_wdata[7])) else $error("core reset does not follow bit 7");
    AST_HIT_NEEDS_REQ: assert property (shm_hit |-> $past(mem_req))
        else $error("memory hit without a request");
    AST_WIDE_SELECT: assert property (!mem_wide_select_n |-> shm_hit && $past(mem_wide_req))
        else $error("wide select without a wide hit");
    AST_SEND_HOLD: assert property (send_packet && cmd_wr && !io_wdata[2] && !tx_done
        && !tx_abort |=> send_packet) else $error("zero write cleared send packet");
    AST_SEND_CLEAR: assert property (send_packet && (tx_done || tx_abort)
        && !(cmd_wr && io_wdata[2]) |=> !send_packet) else $error("send packet not cleared");
    AST_TX_START: assert property (tx_start |-> send_packet && !$past(send_packet))
        else $error("transmit start without a new send");
    AST_CFG_OPEN: assert property (cfg_wr && new_page_enable && page_choice
        |=> {config_ab_writable, core_clock_source, irq_output_style, full_buffer_mode}
        == {!$past(io_wdata[7]), $past(io_wdata[6:4])}) else $error("config C write lost");
    AST_CFG_CLOSED: assert property (io_wr && !(new_page_enable && page_choice)
        |=> $stable(core_clock_source) && $stable(config_ab_writable))
        else $error("config C changed while closed");
    // The status bit is the pin registered once, so the read shows the pin of two edges back.
    AST_SLOT_READ: assert property (shm_rd && io_addr[1:0] == 2'h1
        |=> io_rdata == {7'h00, $past(slot_width_pin, 2)}) else $error("slot status wrong");
    AST_CTL2_GAP: assert property (shm_rd && io_addr[1:0] == 2'h2 |=> !io_rdata[5])
        else $error("control 2 bit 5 not zero");
    AST_DMA_ABORT: assert property (cmd_wr && io_wdata[5] |=> rdma_abort && !rdma_busy)
        else $error("abort not taken");
    AST_FINISH_NOW: assert property (cmd_wr && !io_wdata[5] && io_wdata[4:3] != 2'h0
        && !rbc_reloaded |=> rdma_finish_now && !rdma_busy) else $error("no early finish");

    COV_TX: cover property (tx_start);
    COV_WIDE_HIT: cover property (shm_hit && !mem_wide_select_n);
    COV_FINISH: cover property (rdma_finish_now);
endmodule

bind smccr_regs smccr_regs_checker u_smccr_regs_checker (.clk, .resetn, .io_addr, .io_wr,
    .io_rd, .io_wdata, .shm_sel, .new_page_enable, .page_choice, .slot_width_pin, .tx_done,
    .tx_abort, .rbc_reloaded, .mem_req, .mem_wide_req, .io_rdata, .irq_output_style,
    .core_clock_source, .full_buffer_mode, .config_ab_writable, .core_reset, .send_packet,
    .tx_start, .rdma_abort, .rdma_finish_now, .rdma_busy, .shm_hit, .mem_wide_select_n);

/* bench/smccr_host.sv */
// Host processor model that makes register cycles on the I/O port.
`timescale 1ns/1ps
module smccr_host (
    input  wire logic       clk,
    input  wire logic       rdma_busy,
    input  wire logic [7:0] io_rdata,
    output logic [4:0]      io_addr,
    output logic            io_wr,
    output logic            io_rd,
    output logic [7:0]      io_wdata,
    output logic            shm_sel
);
    logic [2:0] dma_cur = 3'h0;
    initial begin
        io_addr = 5'h00;
        io_wr = 1'b0;
        io_rd = 1'b0;
        io_wdata = 8'h00;
        shm_sel = 1'b0;
    end
    // Released data is inverted so that a stale byte can never look valid.
    task automatic wr(input logic sel, input logic [4:0] a, input logic [7:0] d);
        @(negedge clk);
        shm_sel = sel;
        io_addr = a;
        io_wdata = d;
        io_wr = 1'b1;
        @(negedge clk);
        io_wr = 1'b0;
        io_wdata = ~d;
    endtask
    task automatic rd(input logic sel, input logic [4:0] a, output logic [7:0] d);
        @(negedge clk);
        shm_sel = sel;
        io_addr = a;
        io_rd = 1'b1;
        @(negedge clk);
        io_rd = 1'b0;
        d = io_rdata;
    endtask
    task automatic cmd(input logic [7:0] d);
        logic [7:0] v;
        v = d;
        if (v[2] && v[5:3] == 3'h0 && rdma_busy) v[5:3] = dma_cur;
        if (rdma_busy && !v[5] && v[4:3] != 2'h0 && v[4:3] != dma_cur[1:0]) begin
            wr(1'b0, 5'h00, {v[7:6], 3'h4, v[2:0]});
        end
        wr(1'b0, 5'h00, v);
        if (v[5]) dma_cur = 3'h0;
        else if (v[4:3] != 2'h0) dma_cur = v[5:3];
    endtask
endmodule

/* bench/shared_mem_config_and_command_regs_tb_top.sv */
// Self-checking testbench for the shared memory control and command registers.
`timescale 1ns/1ps
module shared_mem_config_and_command_regs_tb_top;
    import smccr_pkg::*;
    logic clk = 1'b0, resetn = 1'b0, new_page_enable = 1'b0, page_choice = 1'b0;
    logic slot_width_pin = 1'b0, tx_done = 1'b0, tx_abort = 1'b0, rdma_done = 1'b0;
    logic rbc_reloaded = 1'b1, mem_req = 1'b0, mem_wide_req = 1'b0;
    logic [23:0] mem_addr = 24'h000000;
    logic [4:0] io_addr;
    logic [7:0] io_wdata, io_rdata, d;
    logic io_wr, io_rd, shm_sel, irq_output_style, core_clock_source, full_buffer_mode;
    logic config_ab_writable, core_reset, run_cmd, halt_cmd, send_packet, tx_start;
    logic rdma_start, rdma_abort, rdma_finish_now, rdma_busy, shm_hit, mem_wide_select_n;
    logic [1:0] page_select;
    logic [2:0] remote_dma_cmd;
    logic [15:0] buf_offset, buf_addr_mask;
    int err_count = 0;
    int n_compared = 0;
    always #5 clk = ~clk;

    smccr_regs u_smccr_regs (.clk, .resetn, .io_addr, .io_wr, .io_rd, .io_wdata, .shm_sel,
        .new_page_enable, .page_choice, .slot_width_pin, .tx_done, .tx_abort, .rdma_done,
        .rbc_reloaded, .mem_addr, .mem_req, .mem_wide_req, .io_rdata, .irq_output_style,
        .core_clock_source, .full_buffer_mode, .config_ab_writable, .core_reset, .run_cmd,
        .halt_cmd, .send_packet, .page_select, .remote_dma_cmd, .tx_start, .rdma_start,
        .rdma_abort, .rdma_finish_now, .rdma_busy, .shm_hit, .mem_wide_select_n, .buf_offset,
        .buf_addr_mask);
    smccr_host u_smccr_host (.clk, .rdma_busy, .io_rdata, .io_addr, .io_wr, .io_rd, .io_wdata,
        .shm_sel);

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic pulse(ref logic s);
        @(negedge clk);
        s = 1'b1;
        @(negedge clk);
        s = 1'b0;
    endtask

    task automatic t_reset;
        u_smccr_host.rd(1'b0, SMCCR_CMD_OFF, d);
        chk(16'(d), 16'h0001, "command after reset");
        u_smccr_host.rd(1'b1, 5'(SMCCR_CTL1_OFF), d);
        chk(16'(d), 16'h0000, "control 1 after reset");
        chk(buf_addr_mask, 16'h1fff, "mask after reset");
        $display("test reset done");
    endtask
    task automatic t_cfgc;
        page_choice = 1'b1;
        u_smccr_host.wr(1'b0, SMCCR_CFGC_OFF_A, 8'hf0);
        u_smccr_host.rd(1'b0, SMCCR_CFGC_OFF_A, d);
        chk(16'(d), 16'h0000, "closed config read");
        chk(16'(config_ab_writable), 16'h0001, "closed config write");
        new_page_enable = 1'b1;
        u_smccr_host.wr(1'b0, SMCCR_CFGC_OFF_A, 8'hf0);
        u_smccr_host.rd(1'b0, SMCCR_CFGC_OFF_B, d);
        chk(16'(d), 16'h00f0, "open config read");
        chk(16'(irq_output_style), 16'h0001, "coded irq");
        chk(16'(core_clock_source), 16'h0001, "bus clock");
        chk(16'(full_buffer_mode), 16'h0001, "full buffer");
        chk(16'(config_ab_writable), 16'h0000, "locked");
        u_smccr_host.wr(1'b0, SMCCR_CFGC_OFF_B, 8'h00);
        chk(16'(irq_output_style), 16'h0000, "direct irq");
        chk(16'(core_clock_source), 16'h0000, "internal clock");
        chk(16'(config_ab_writable), 16'h0001, "unlocked");
        $display("test config C done");
    endtask
    task automatic t_window;
        logic [7:0] cfg[4] = '{8'h00, 8'h00, 8'h10, 8'h10};
        logic [7:0] ct2[4] = '{8'h00, 8'hc0, 8'h40, 8'hc0};
        logic [15:0] msk[4] = '{16'h1fff, 16'h3fff, 16'h7fff, 16'hffff};
        for (int i = 0; i < 4; i++) begin
            u_smccr_host.wr(1'b0, SMCCR_CFGC_OFF_A, cfg[i]);
            u_smccr_host.wr(1'b1, 5'(SMCCR_CTL2_OFF), ct2[i]);
            // The mask is registered from the stored fields, so it shows a cycle later.
            @(negedge clk);
            chk(buf_addr_mask, msk[i], "window mask");
        end
        u_smccr_host.wr(1'b0, SMCCR_CFGC_OFF_A, 8'h00);
        u_smccr_host.wr(1'b1, 5'(SMCCR_CTL2_OFF), 8'h00);
        u_smccr_host.wr(1'b1, 5'(SMCCR_CTL1_OFF), 8'h05);
        mem_req = 1'b1;
        mem_addr = 24'h00a123;
        repeat (2) @(negedge clk);
        chk(16'(shm_hit), 16'h0000, "hit while disabled");
        u_smccr_host.wr(1'b1, 5'(SMCCR_CTL1_OFF), 8'h45);
        @(negedge clk);
        chk(16'(shm_hit), 16'h0001, "hit low base");
        chk(buf_offset, 16'h0123, "buffer offset");
        u_smccr_host.wr(1'b1, 5'(SMCCR_CTL2_OFF), 8'h81);
        mem_addr = 24'h08a123;
        mem_wide_req = 1'b1;
        repeat (2) @(negedge clk);
        chk(16'(shm_hit), 16'h0001, "hit high base");
        chk(16'(mem_wide_select_n), 16'h0000, "wide select");
        mem_wide_req = 1'b0;
        @(negedge clk);
        chk(16'(mem_wide_select_n), 16'h0001, "narrow request");
        mem_wide_req = 1'b1;
        u_smccr_host.wr(1'b1, 5'(SMCCR_CTL2_OFF), 8'h01);
        @(negedge clk);
        chk(16'(mem_wide_select_n), 16'h0001, "wide select off");
        mem_addr = 24'h00a123;
        repeat (2) @(negedge clk);
        chk(16'(shm_hit), 16'h0000, "miss high base");
        mem_req = 1'b0;
        mem_wide_req = 1'b0;
        u_smccr_host.wr(1'b1, 5'(SMCCR_CTL2_OFF), 8'hff);
        u_smccr_host.rd(1'b1, 5'(SMCCR_CTL2_OFF), d);
        chk(16'(d), 16'h00df, "control 2 readback");
        new_page_enable = 1'b0;
        page_choice = 1'b0;
        u_smccr_host.wr(1'b0, SMCCR_CFGC_OFF_A, 8'h10);
        chk(16'(full_buffer_mode), 16'h0000, "config C stays closed");
        $display("test window done");
    endtask
    task automatic t_slot;
        slot_width_pin = 1'b1;
        u_smccr_host.rd(1'b1, 5'(SMCCR_SLOT_OFF), d);
        chk(16'(d), 16'h0001, "wide slot");
        slot_width_pin = 1'b0;
        u_smccr_host.rd(1'b1, 5'(SMCCR_SLOT_OFF), d);
        chk(16'(d), 16'h0000, "narrow slot");
        $display("test slot done");
    endtask
    task automatic t_cmd;
        u_smccr_host.cmd(8'h06);
        chk(16'({run_cmd, send_packet, tx_start, halt_cmd}), 16'he, "run and send");
        u_smccr_host.cmd(8'h02);
        chk(16'(send_packet), 16'h0001, "zero to send ignored");
        u_smccr_host.cmd(8'h12);
        chk(16'({rdma_start, rdma_busy}), 16'h0003, "dma start");
        u_smccr_host.cmd(8'h06);
        chk(16'(remote_dma_cmd), 16'h0002, "dma kept on send");
        pulse(tx_done);
        chk(16'(send_packet), 16'h0000, "send cleared on done");
        pulse(rdma_done);
        chk(16'(rdma_busy), 16'h0000, "dma done");
        u_smccr_host.cmd(8'h22);
        chk(16'({rdma_abort, rdma_busy}), 16'h0002, "dma abort");
        rbc_reloaded = 1'b0;
        u_smccr_host.cmd(8'h0e);
        chk(16'({rdma_finish_now, rdma_busy}), 16'h0002, "early finish");
        rbc_reloaded = 1'b1;
        pulse(tx_abort);
        chk(16'(send_packet), 16'h0000, "send cleared on abort");
        u_smccr_host.cmd(8'hc1);
        chk(16'({page_select, halt_cmd}), 16'h0007, "page and halt");
        u_smccr_host.rd(1'b0, SMCCR_CMD_OFF, d);
        chk(16'(d), 16'h00c1, "command readback");
        $display("test command done");
    endtask
    task automatic t_core_reset;
        u_smccr_host.wr(1'b1, 5'(SMCCR_CTL1_OFF), 8'h80);
        chk(16'(core_reset), 16'h0001, "core reset set");
        u_smccr_host.wr(1'b1, 5'(SMCCR_CTL1_OFF), 8'h00);
        chk(16'(core_reset), 16'h0000, "core reset clear");
        $display("test core reset done");
    endtask

    task automatic summarize;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        repeat (4) @(negedge clk);
        resetn = 1'b1;
        t_reset();
        t_cfgc();
        t_window();
        t_slot();
        t_cmd();
        t_core_reset();
        summarize();
    end
    // The tests need well under 300 cycles, so this bound only trips on a hang.
    initial begin
        #20us;
        err_count++;
        summarize();
    end
endmodule
